// ==== hw/sync_ctrl_pkg.sv ====
// Package: constants and carriers for buffer sync and clock mode control
package sync_ctrl_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL24 = 8'h04;
  localparam logic [7:0] ADDR_CTRL26 = 8'h08;
  localparam logic [7:0] ADDR_CTRL32 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field positions
  localparam int BUF_ENA_BIT = 0;
  localparam int PLL_ENA_BIT = 0;
  localparam int CP_LSB = 1;
  localparam int PRESCALE_LSB = 3;
  localparam int FBDIV_LSB = 8;
  localparam int SLEEP_BIT = 0;
  localparam int COARSE_LSB = 1;
  localparam int RDSEL_LSB = 0;
  localparam int WRSEL_LSB = 4;

  // Sync-select bit meanings
  localparam int SEL_SYNC = 0;
  localparam int SEL_FRAME = 1;
  localparam int SEL_STROBE = 2;
  localparam int SEL_SIF = 3;

  // Charge-pump codes
  localparam logic [1:0] CP_SINGLE = 2'h1;
  localparam logic [1:0] CP_DOUBLE = 2'h3;

  // Reset values
  localparam logic [31:0] CTRL0_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL24_RST = 32'h0000_0400;
  localparam logic [31:0] CTRL26_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL32_RST = 32'h0000_0000;

  // Buffer geometry
  localparam logic [2:0] WR_PTR_RST = 3'h0;
  localparam logic [2:0] RD_PTR_RST = 3'h4;
  localparam int BUF_DEPTH = 8;

  // Clock switch settle count in cycles
  localparam logic [2:0] SWITCH_SETTLE = 3'h3;

  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_DUAL = 2'h1,
    MODE_SINGLE = 2'h3,
    MODE_NONE = 2'h2
  } buf_mode_t;

  typedef enum logic [1:0] {
    CLK_DIRECT = 2'h0,
    CLK_STOP_TO_PLL = 2'h1,
    CLK_PLL = 2'h3,
    CLK_STOP_TO_DIRECT = 2'h2
  } clk_state_t;

  // PLL settings carrier
  typedef struct packed {
    logic use_pll;
    logic sleep;
    logic [2:0] prescale;
    logic [7:0] fbdiv;
    logic [5:0] coarse;
    logic double_cp;
  } pll_cfg_t;

  // Sample carrier: four 16-bit channels
  typedef struct packed {
    logic [15:0] ch_a;
    logic [15:0] ch_b;
    logic [15:0] ch_c;
    logic [15:0] ch_d;
  } sample_t;

endpackage : sync_ctrl_pkg

// ==== hw/fb_divider.sv ====
// Programmable divider producing a one-cycle pulse every code cycles
`timescale 1ns/1ns
`default_nettype none
module fb_divider
  import sync_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic enable_i,
  input wire logic resync_i,
  input wire logic [7:0] div_i,
  // Output
  output logic tick_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  // Count down from div value; code equals divide ratio, zero acts as one
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!enable_i || resync_i) begin
      s_d.cnt = 8'h00;
    end else if (s_q.cnt == 8'h00 || s_q.cnt == 8'h01) begin
      s_d.cnt = div_i;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule : fb_divider
`default_nettype wire

// ==== hw/sync_clock_ctrl.sv ====
// Buffer sync mode and sample-clock source control with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module sync_clock_ctrl
  import sync_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sync pins, asynchronous
  input wire logic frame_i,
  input wire logic sync_i,
  input wire logic output_strobe_i,
  input wire logic sif_sync_i,
  // Data from input data clock side, asynchronous word
  input wire logic [63:0] in_sample_i,
  input wire logic in_write_i,
  // Outputs
  output logic [63:0] out_sample_o,
  output logic out_valid_o,
  output logic [2:0] wr_ptr_o,
  output logic [2:0] rd_ptr_o,
  output logic use_pll_clk_o,
  output logic clk_gate_o,
  output logic pll_sleep_o,
  output logic [2:0] pll_prescale_o,
  output logic [7:0] pll_fbdiv_o,
  output logic [5:0] pll_coarse_o,
  output logic pll_double_cp_o,
  output logic int_strobe_o
);

  typedef struct packed {
    logic [31:0] ctrl0;
    logic [31:0] ctrl24;
    logic [31:0] ctrl26;
    logic [31:0] ctrl32;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic wr_s1;
    logic wr_s2;
    logic wr_s3;
    logic [63:0] smp_s1;
    logic [63:0] smp_s2;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [63:0] out_sample;
    logic out_valid;
    sample_t [BUF_DEPTH-1:0] mem;
    clk_state_t clk_st;
    logic [2:0] settle;
    logic use_pll;
    logic clk_gate;
    logic strobe;
    logic double_cp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic fb_tick;

  // Register readback decode, shared by read path
  function automatic logic [31:0] read_reg(input state_t st, input logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      ADDR_CTRL0: v = st.ctrl0;
      ADDR_CTRL24: v = st.ctrl24;
      ADDR_CTRL26: v = st.ctrl26;
      ADDR_CTRL32: v = st.ctrl32;
      ADDR_STATUS: v = {21'h00_0000, st.clk_st, st.use_pll, st.rd_ptr, st.wr_ptr,
                        buf_mode(st.ctrl0, st.ctrl32)};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_reg

  // Buffer mode decode
  function automatic buf_mode_t buf_mode(input logic [31:0] c0, input logic [31:0] c32);
    logic [3:0] rsel;
    buf_mode_t m;
    rsel = c32[RDSEL_LSB +: 4];
    if (!c0[BUF_ENA_BIT]) begin
      m = MODE_BYPASS;
    end else if (rsel == 4'h4) begin
      m = MODE_DUAL;
    end else if (rsel[SEL_FRAME] || rsel[SEL_SYNC]) begin
      m = MODE_SINGLE;
    end else begin
      m = MODE_NONE;
    end
    return m;
  endfunction : buf_mode

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Phase-detector tick from feedback divider
  fb_divider i_fb_divider (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .enable_i(s_q.use_pll),
    .resync_i(s_q.clk_st != CLK_PLL),
    .div_i(s_q.ctrl24[FBDIV_LSB +: 8]),
    .tick_o(fb_tick)
  );

  // Next-state logic
  always_comb begin
    logic [3:0] rise;
    logic wr_rise;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic strobe_src;
    logic wr_reset;
    logic rd_reset;
    buf_mode_t mode;
    logic want_pll;
    s_d = s_q;
    // Two-flop pin synchronisers, third stage for edge detection
    s_d.pin_s1 = {sif_sync_i, output_strobe_i, frame_i, sync_i};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    s_d.wr_s1 = in_write_i;
    s_d.wr_s2 = s_q.wr_s1;
    s_d.wr_s3 = s_q.wr_s2;
    // Data word synchroniser; word is held steady around its write edge
    s_d.smp_s1 = in_sample_i;
    s_d.smp_s2 = s_q.smp_s1;
    rise = s_q.pin_s2 & ~s_q.pin_s3;
    wr_rise = s_q.wr_s2 & ~s_q.wr_s3;
    wsel = s_q.ctrl32[WRSEL_LSB +: 4];
    rsel = s_q.ctrl32[RDSEL_LSB +: 4];
    mode = buf_mode(s_q.ctrl0, s_q.ctrl32);
    // Strobe source: internal in PLL mode, pin otherwise
    strobe_src = s_q.use_pll ? s_q.strobe : rise[SEL_STROBE];
    s_d.strobe = fb_tick;
    // Pointer resets from selected rising edges; empty selects give none outside single mode
    wr_reset = |(wsel & rise & 4'hB);
    rd_reset = 1'b0;
    unique case (mode)
      MODE_DUAL: begin
        wr_reset = |(wsel & rise & 4'hB) | rise[SEL_FRAME] & (wsel == 4'h0) & 1'b0;
        rd_reset = strobe_src;
      end
      MODE_SINGLE: begin
        rd_reset = |(rsel & rise & 4'h3);
        wr_reset = wr_reset | rd_reset;
      end
      MODE_NONE: begin
        rd_reset = |(rsel & rise & 4'h8);
      end
      MODE_BYPASS: begin
        rd_reset = 1'b0;
      end
    endcase
    // Write side: sample written on each synchronised write strobe outside bypass, unless a write-pointer reset
    s_d.out_valid = 1'b0;
    if (wr_reset) begin
      s_d.wr_ptr = WR_PTR_RST;
    end else if (wr_rise && mode != MODE_BYPASS) begin
      s_d.mem[s_q.wr_ptr] = s_q.smp_s2;
      s_d.wr_ptr = s_q.wr_ptr + 3'h1;
    end
    // Read side and bypass path
    if (mode == MODE_BYPASS) begin
      if (wr_rise) begin
        s_d.out_sample = s_q.smp_s2;
        s_d.out_valid = 1'b1;
      end
    end else if (rd_reset) begin
      s_d.rd_ptr = RD_PTR_RST;
    end else if (wr_rise) begin
      s_d.out_sample = s_q.mem[s_q.rd_ptr];
      s_d.out_valid = 1'b1;
      s_d.rd_ptr = s_q.rd_ptr + 3'h1;
    end
    // Clock source selection with gated hand-over
    want_pll = s_q.ctrl24[PLL_ENA_BIT] & ~s_q.ctrl26[SLEEP_BIT];
    unique case (s_q.clk_st)
      CLK_DIRECT: begin
        s_d.clk_gate = 1'b1;
        if (want_pll) begin
          s_d.clk_gate = 1'b0;
          s_d.settle = SWITCH_SETTLE;
          s_d.clk_st = CLK_STOP_TO_PLL;
        end
      end
      CLK_STOP_TO_PLL: begin
        if (s_q.settle != 3'h0) begin
          s_d.settle = s_q.settle - 3'h1;
        end else begin
          s_d.use_pll = 1'b1;
          s_d.clk_gate = 1'b1;
          s_d.clk_st = CLK_PLL;
        end
      end
      CLK_PLL: begin
        if (!want_pll) begin
          s_d.clk_gate = 1'b0;
          s_d.settle = SWITCH_SETTLE;
          s_d.clk_st = CLK_STOP_TO_DIRECT;
        end
      end
      CLK_STOP_TO_DIRECT: begin
        if (s_q.settle != 3'h0) begin
          s_d.settle = s_q.settle - 3'h1;
        end else begin
          s_d.use_pll = 1'b0;
          s_d.clk_gate = 1'b1;
          s_d.clk_st = CLK_DIRECT;
        end
      end
    endcase
    // AXI write channels, accepted in either order
    if (s_axi_awvalid && !s_q.aw_hold && !s_q.bvalid) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_hold && !s_q.bvalid) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_hold && s_q.w_hold) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      unique case (s_q.aw_addr)
        ADDR_CTRL0: s_d.ctrl0 = merge(s_q.ctrl0, s_q.w_data, s_q.w_strb);
        ADDR_CTRL24: s_d.ctrl24 = merge(s_q.ctrl24, s_q.w_data, s_q.w_strb);
        ADDR_CTRL26: s_d.ctrl26 = merge(s_q.ctrl26, s_q.w_data, s_q.w_strb);
        ADDR_CTRL32: s_d.ctrl32 = merge(s_q.ctrl32, s_q.w_data, s_q.w_strb);
        ADDR_STATUS: s_d.bresp = 2'h0;
        default: s_d.bresp = 2'h2;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // AXI read channel
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_reg(s_q, s_axi_araddr);
      s_d.rresp = (s_axi_araddr > ADDR_STATUS || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // Registered handshake readies and pump flag
    s_d.aw_rdy = !s_d.aw_hold && !s_d.bvalid;
    s_d.w_rdy = !s_d.w_hold && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
    s_d.double_cp = s_d.ctrl24[CP_LSB +: 2] == CP_DOUBLE;
  end

  // State register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.ctrl0 <= CTRL0_RST;
      s_q.ctrl24 <= CTRL24_RST;
      s_q.ctrl26 <= CTRL26_RST;
      s_q.ctrl32 <= CTRL32_RST;
      s_q.wr_ptr <= WR_PTR_RST;
      s_q.rd_ptr <= RD_PTR_RST;
      s_q.clk_st <= CLK_DIRECT;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus outputs straight from state
  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Data and clock-control outputs
  assign out_sample_o = s_q.out_sample;
  assign out_valid_o = s_q.out_valid;
  assign wr_ptr_o = s_q.wr_ptr;
  assign rd_ptr_o = s_q.rd_ptr;
  assign use_pll_clk_o = s_q.use_pll;
  assign clk_gate_o = s_q.clk_gate;
  assign pll_sleep_o = s_q.ctrl26[SLEEP_BIT];
  assign pll_prescale_o = s_q.ctrl24[PRESCALE_LSB +: 3];
  assign pll_fbdiv_o = s_q.ctrl24[FBDIV_LSB +: 8];
  assign pll_coarse_o = s_q.ctrl26[COARSE_LSB +: 6];
  assign pll_double_cp_o = s_q.double_cp;
  assign int_strobe_o = s_q.strobe;

endmodule : sync_clock_ctrl
`default_nettype wire

// ==== test/sync_clock_chk.sv ====
// Checker: bus answers and clock-switch behaviour of the control block
`timescale 1ns/1ns
`default_nettype none
module sync_clock_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Data and clock control outputs
  input wire logic out_valid_o,
  input wire logic use_pll_clk_o,
  input wire logic clk_gate_o,
  input wire logic pll_sleep_o,
  input wire logic [7:0] pll_fbdiv_o,
  input wire logic int_strobe_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // Answers stand until taken
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Source changes only behind a closed gate, and the gate reopens soon
  a_switch_gated: assert property ($changed(use_pll_clk_o) |-> !$past(clk_gate_o))
    else $error("clock source changed with gate open");
  a_gate_bounded: assert property ($fell(clk_gate_o) |-> ##[1:6] clk_gate_o)
    else $error("gate stayed closed");
  a_pll_awake: assert property ($rose(use_pll_clk_o) |-> !pll_sleep_o)
    else $error("multiplied clock chosen while asleep");
  // Internal strobe only in multiplied mode, once per divider period
  a_strobe_pll: assert property (int_strobe_o |-> use_pll_clk_o)
    else $error("strobe without multiplied clock");
  a_strobe_period: assert property (
    int_strobe_o && pll_fbdiv_o == 8'h04 |=> !int_strobe_o [*3]
    ##1 (int_strobe_o || !clk_gate_o || !use_pll_clk_o))
    else $error("strobe period wrong");
  a_sample_pulse: assert property (out_valid_o |=> !out_valid_o)
    else $error("sample strobe too long");

  // Main scenarios reached
  c_pll_on: cover property ($rose(use_pll_clk_o));
  c_strobe: cover property (int_strobe_o);
  c_sample: cover property (out_valid_o);
endmodule : sync_clock_chk
`default_nettype wire

// ==== test/sync_far_side.sv ====
// Far-side model: sync pin edges and data words toward the block
`timescale 1ns/1ns
`default_nettype none
module sync_far_side (
  // Clock
  input wire logic core_clk_i,
  // Pins toward the block
  output var logic [3:0] sync_pins_o,
  output var logic [63:0] sample_o,
  output var logic write_o
);
  // Idle levels
  initial begin
    sync_pins_o = 4'h0;
    sample_o = 64'h0;
    write_o = 1'b0;
  end

  // One single rising edge, never a periodic train
  task pulse(input int idx);
    @(posedge core_clk_i);
    sync_pins_o[idx] <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sync_pins_o[idx] <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : pulse

  // Word held around the write edge, then spoiled
  task send(input logic [63:0] w);
    @(posedge core_clk_i);
    sample_o <= w;
    repeat (4) @(posedge core_clk_i);
    write_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    write_o <= 1'b0;
    sample_o <= ~w;
    repeat (4) @(posedge core_clk_i);
  endtask : send
endmodule : sync_far_side
`default_nettype wire

// ==== test/tb_sync_clock_ctrl.sv ====
// Testbench: registers, buffer modes, pointer sync and clock switching
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("wrong value at %0t: %h not %h", $time, (g), (e)); \
    end \
  end
module tb_sync_clock_ctrl;
  import sync_ctrl_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, m1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, out_valid, use_pll, gate, sleep;
  wire logic dcp, strobe, wrt;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [63:0] out_sample, sample;
  wire logic [2:0] wr_ptr, rd_ptr, prescale;
  wire logic [7:0] fbdiv;
  wire logic [5:0] coarse;
  wire logic [3:0] pins;
  logic [33:0] exp_q[$], e1;
  logic [31:0] msk_q[$];
  logic [63:0] samp_q[$], w, w1;
  logic [7:0] sel_tab[4] = '{8'h14, 8'h22, 8'h11, 8'h00};
  buf_mode_t mode_tab[4] = '{MODE_DUAL, MODE_SINGLE, MODE_SINGLE, MODE_NONE};
  logic [1:0] cp_tab[2] = '{CP_SINGLE, CP_DOUBLE};
  logic [5:0] ct;
  int num_errors = 0;
  int checked = 0;
  int n;

  always #25 core_clk_i = ~core_clk_i;

  sync_clock_ctrl i_sync_clock_ctrl (
    .core_clk_i(core_clk_i), .reset_i(reset_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .frame_i(pins[SEL_FRAME]), .sync_i(pins[SEL_SYNC]), .output_strobe_i(pins[SEL_STROBE]),
    .sif_sync_i(pins[SEL_SIF]), .in_sample_i(sample), .in_write_i(wrt),
    .out_sample_o(out_sample), .out_valid_o(out_valid), .wr_ptr_o(wr_ptr), .rd_ptr_o(rd_ptr),
    .use_pll_clk_o(use_pll), .clk_gate_o(gate), .pll_sleep_o(sleep),
    .pll_prescale_o(prescale), .pll_fbdiv_o(fbdiv), .pll_coarse_o(coarse),
    .pll_double_cp_o(dcp), .int_strobe_o(strobe));

  sync_far_side i_sync_far_side (.core_clk_i(core_clk_i), .sync_pins_o(pins),
    .sample_o(sample), .write_o(wrt));

  task print_verdict;
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task give_up;
    num_errors++;
    print_verdict();
  endtask : give_up

  // Bus write; expected response noted for the monitor
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    msk_q.push_back(32'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    @(posedge core_clk_i);
    if (n >= 40) give_up();
  endtask : wr

  // Bus read; masked expected word noted for the monitor
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
          input logic [1:0] r);
    exp_q.push_back({r, e & m});
    msk_q.push_back(m);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    @(posedge core_clk_i);
    if (n >= 40) give_up();
  endtask : rd

  // Bounded wait for the selected source, then strobes in 16 cycles
  task settle(input logic v);
    n = 0;
    while (use_pll !== v && n < 40) begin
      @(posedge core_clk_i);
      n++;
    end
    `CHK(use_pll, v)
    repeat (8) @(posedge core_clk_i);
    n = 0;
    repeat (16) begin
      @(posedge core_clk_i);
      if (strobe === 1'b1) n++;
    end
  endtask : settle

  // Monitor: each answer against the oldest note
  always @(posedge core_clk_i) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e1 = exp_q.pop_front();
      m1 = msk_q.pop_front();
      `CHK({bvalid ? bresp : rresp, bvalid ? 32'h0 : rdata & m1}, e1)
    end
    if (out_valid && samp_q.size() > 0) begin
      w1 = samp_q.pop_front();
      `CHK(out_sample, w1)
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    give_up();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h272D));
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    rd(ADDR_CTRL0, CTRL0_RST, 32'hFFFF_FFFF, 2'h0);
    rd(ADDR_CTRL24, CTRL24_RST, 32'hFFFF_FFFF, 2'h0);
    rd(ADDR_CTRL26, CTRL26_RST, 32'hFFFF_FFFF, 2'h0);
    rd(ADDR_CTRL32, CTRL32_RST, 32'hFFFF_FFFF, 2'h0);
    wr(8'h14, 32'h0, 2'h2);
    rd(8'h14, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(ADDR_STATUS, 32'hFFFF_FFFF, 2'h0);
    rd(ADDR_STATUS, 32'h2, 32'h703, 2'h0);
    foreach (sel_tab[i]) begin
      wr(ADDR_CTRL32, {24'h0, sel_tab[i]}, 2'h0);
      rd(ADDR_STATUS, {30'h0, mode_tab[i]}, 32'h3, 2'h0);
    end
    // Pointer sync: none selected, then sync, then frame
    i_sync_far_side.send(64'h0123_4567_89AB_CDEF);
    i_sync_far_side.pulse(SEL_SYNC);
    `CHK(wr_ptr, 3'h1)
    wr(ADDR_CTRL32, 32'h14, 2'h0);
    i_sync_far_side.pulse(SEL_SYNC);
    `CHK(wr_ptr, WR_PTR_RST)
    i_sync_far_side.pulse(SEL_STROBE);
    `CHK(rd_ptr, RD_PTR_RST)
    wr(ADDR_CTRL32, 32'h22, 2'h0);
    i_sync_far_side.send(64'hFEDC_BA98_7654_3210);
    i_sync_far_side.pulse(SEL_FRAME);
    `CHK(wr_ptr, WR_PTR_RST)
    `CHK(rd_ptr, RD_PTR_RST)
    // Multiplied clock with both pump currents, then back to direct
    wr(ADDR_CTRL32, 32'h14, 2'h0);
    ct = 6'($urandom_range(63));
    foreach (cp_tab[i]) begin
      wr(ADDR_CTRL24, {16'h0, 8'h04, 2'h0, 3'h7, cp_tab[i], 1'b1}, 2'h0);
      wr(ADDR_CTRL26, {25'h0, ct, 1'b0}, 2'h0);
      `CHK(dcp, cp_tab[i] == CP_DOUBLE)
    end
    settle(1'b1);
    `CHK(n, 4)
    `CHK({sleep, prescale, fbdiv, coarse}, {1'b0, 3'h7, 8'h04, ct})
    rd(ADDR_STATUS, 32'h700, 32'h700, 2'h0);
    wr(ADDR_CTRL24, CTRL24_RST, 2'h0);
    wr(ADDR_CTRL26, 32'h1, 2'h0);
    settle(1'b0);
    `CHK(n, 0)
    `CHK(sleep, 1'b1)
    // Bypass: words pass straight through
    wr(ADDR_CTRL0, 32'h0, 2'h0);
    rd(ADDR_STATUS, 32'h0, 32'h3, 2'h0);
    repeat (2) begin
      w = {$urandom, $urandom};
      samp_q.push_back(w);
      i_sync_far_side.send(w);
    end
    `CHK(samp_q.size(), 0)
    print_verdict();
  end
endmodule : tb_sync_clock_ctrl

bind sync_clock_ctrl sync_clock_chk i_sync_clock_chk (.core_clk_i, .reset_i,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .out_valid_o, .use_pll_clk_o,
  .clk_gate_o, .pll_sleep_o, .pll_fbdiv_o, .int_strobe_o);
`default_nettype wire
